/* File: rtl/drive_output_pkg.sv */
// Shared constants, types and helpers for the status output assignment block.
package drive_output_pkg;

    // Structure sizes.
    localparam int TERM_N = 5;       // Outputs a, b, c, aux relay, fault relay.
    localparam int CODE_W = 11;      // Wide enough for select codes up to 1099.
    localparam int FREQ_W = 16;      // Frequencies in steps of 0.01 Hz.
    localparam int VOLT_W = 16;      // Bus voltage in raw converter counts.
    localparam int IRQ_W  = 5;       // Number of interrupt events.
    localparam int ADDR_W = 8;       // Decoded APB address bits.
    localparam int STAGE_N = 7;      // Motor staging flags.

    // Terminal indices.
    localparam int TERM_A     = 0;
    localparam int TERM_B     = 1;
    localparam int TERM_C     = 2;
    localparam int TERM_AUX   = 3;
    localparam int TERM_FAULT = 4;

    // Select codes; the inverted form is the base code plus 1000 (0x3E8).
    localparam logic [CODE_W-1:0] INVERT_OFFSET = 11'h3E8;
    localparam logic [CODE_W-1:0] CODE_RUNNING  = 11'h000;
    localparam logic [CODE_W-1:0] CODE_REACHED  = 11'h001;
    localparam logic [CODE_W-1:0] CODE_THRESH   = 11'h002;
    localparam logic [CODE_W-1:0] CODE_BUS_LOW  = 11'h003;
    localparam logic [CODE_W-1:0] CODE_LIMITING = 11'h005;
    localparam logic [CODE_W-1:0] CODE_RESTART  = 11'h006;
    localparam logic [CODE_W-1:0] CODE_OVERLOAD = 11'h007;
    localparam logic [CODE_W-1:0] CODE_READY    = 11'h00A;
    localparam logic [CODE_W-1:0] CODE_LINE     = 11'h00B;
    localparam logic [CODE_W-1:0] CODE_SECOND   = 11'h00C;
    localparam logic [CODE_W-1:0] CODE_PRIMARY  = 11'h00D;
    localparam logic [CODE_W-1:0] CODE_OVERHEAT = 11'h038;
    localparam logic [CODE_W-1:0] CODE_STAGE_LO = 11'h03C;
    localparam logic [CODE_W-1:0] CODE_STAGE_HI = 11'h041;
    localparam logic [CODE_W-1:0] CODE_STAGE_4L = 11'h043;
    localparam logic [CODE_W-1:0] CODE_PERIODIC = 11'h044;
    localparam logic [CODE_W-1:0] CODE_PUMP     = 11'h045;
    localparam logic [CODE_W-1:0] CODE_FAULT    = 11'h063;

    // Comparator bands in 0.01 Hz: 2.5 Hz arrival window, 1 Hz hysteresis.
    localparam logic [FREQ_W-1:0] ARRIVAL_TOL = 16'h00FA;
    localparam logic [FREQ_W-1:0] DETECT_HYST = 16'h0064;

    // Byte offsets of the registers; select code t sits at 4*t.
    localparam logic [ADDR_W-1:0] OFS_CODE0      = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DETECT     = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_START      = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STOP       = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_UV         = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_FLAGS      = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 8'h2C;

    // Reset values; every select code resets to active-on polarity.
    localparam logic [TERM_N-1:0][CODE_W-1:0] RST_CODES =
        {11'h063, 11'h00A, 11'h002, 11'h001, 11'h000};
    localparam logic [FREQ_W-1:0] RST_DETECT = 16'h1770;
    localparam logic [FREQ_W-1:0] RST_START  = 16'h0032;
    localparam logic [FREQ_W-1:0] RST_STOP   = 16'h0032;
    localparam logic [VOLT_W-1:0] RST_UV     = 16'h00C8;
    localparam logic [IRQ_W-1:0]  RST_MASK   = 5'h00;

    // Interrupt bit positions.
    localparam int IRQ_RUNNING = 0;
    localparam int IRQ_REACHED = 1;
    localparam int IRQ_THRESH  = 2;
    localparam int IRQ_BUS_LOW = 3;
    localparam int IRQ_REJECT  = 4;

    // Flags produced by the rest of the drive.
    typedef struct packed {
        logic                  output_limiting_flag;
        logic                  power_loss_restart_flag;
        logic                  overload_warning_flag;
        logic                  ready;
        logic                  line_contactor_drive;
        logic                  secondary_contactor_drive;
        logic                  primary_contactor_drive;
        logic                  motor_overheat_flag;
        logic [STAGE_N-1:0]    motor_stage;
        logic                  periodic_switch_warning;
        logic                  pump_limit_flag;
        logic                  any_fault_flag;
    } ext_flags_t;

    // All selectable flags, local ones first.
    typedef struct packed {
        logic       running;
        logic       speed_reached_flag;
        logic       speed_threshold_flag;
        logic       dc_bus_low_flag;
        ext_flags_t ext;
    } flags_t;

    // APB request and answer.
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    // Strips the polarity offset from a select code.
    function automatic logic [CODE_W-1:0] base_of(logic [CODE_W-1:0] code);
        base_of = (code >= INVERT_OFFSET) ? code - INVERT_OFFSET : code;
    endfunction : base_of

    // True when a code names a supported flag with an allowed polarity.
    function automatic logic code_valid(logic [CODE_W-1:0] code);
        logic [CODE_W-1:0] b;
        logic              inv;
        b   = base_of(code);
        inv = (code >= INVERT_OFFSET);
        case (b)
            CODE_RUNNING, CODE_REACHED, CODE_THRESH, CODE_BUS_LOW,
            CODE_LIMITING, CODE_RESTART, CODE_OVERLOAD, CODE_READY,
            CODE_OVERHEAT, CODE_PERIODIC, CODE_PUMP, CODE_FAULT,
            CODE_STAGE_4L: code_valid = 1'b1;
            CODE_LINE, CODE_SECOND, CODE_PRIMARY: code_valid = !inv;
            default: code_valid = (b >= CODE_STAGE_LO) && (b <= CODE_STAGE_HI);
        endcase
    endfunction : code_valid

endpackage : drive_output_pkg

/* File: rtl/status_select_mux.sv */
// Picks one status flag by select code and applies the code's polarity.
`timescale 1ns/100ps

module status_select_mux
    import drive_output_pkg::*;
(
    input  wire logic [CODE_W-1:0] code,   // Stored select code.
    input  wire flags_t            flags,  // Every selectable flag.
    output logic                   level   // Flag after polarity.
);

    // Pure lookup; the caller registers the result.
    always_comb begin
        logic [CODE_W-1:0] b;
        logic              sel;
        logic              inv;
        sel = 1'b0;
        b   = base_of(code);
        inv = (code >= INVERT_OFFSET);
        case (b)
            CODE_RUNNING:  sel = flags.running;
            CODE_REACHED:  sel = flags.speed_reached_flag;
            CODE_THRESH:   sel = flags.speed_threshold_flag;
            CODE_BUS_LOW:  sel = flags.dc_bus_low_flag;
            CODE_LIMITING: sel = flags.ext.output_limiting_flag;
            CODE_RESTART:  sel = flags.ext.power_loss_restart_flag;
            CODE_OVERLOAD: sel = flags.ext.overload_warning_flag;
            CODE_READY:    sel = flags.ext.ready;
            CODE_LINE:     sel = flags.ext.line_contactor_drive;
            CODE_SECOND:   sel = flags.ext.secondary_contactor_drive;
            CODE_PRIMARY:  sel = flags.ext.primary_contactor_drive;
            CODE_OVERHEAT: sel = flags.ext.motor_overheat_flag;
            CODE_STAGE_4L: sel = flags.ext.motor_stage[STAGE_N-1];
            CODE_PERIODIC: sel = flags.ext.periodic_switch_warning;
            CODE_PUMP:     sel = flags.ext.pump_limit_flag;
            CODE_FAULT:    sel = flags.ext.any_fault_flag;
            default: begin
                // Staging codes 60 to 65 map onto stage bits 0 to 5.
                if (b >= CODE_STAGE_LO && b <= CODE_STAGE_HI) begin
                    sel = flags.ext.motor_stage[3'(b - CODE_STAGE_LO)];
                end else begin
                    sel = 1'b0;
                end
            end
        endcase
        level = sel ^ inv;
    end

endmodule : status_select_mux

/* File: rtl/status_output_assign_mux.sv */
// Programmable status output terminals with flag logic and APB registers.
`timescale 1ns/100ps

module status_output_assign_mux
    import drive_output_pkg::*;
(
    input  wire logic              clock,          // 25 MHz control clock.
    input  wire logic              rstn,           // Asynchronous, active low.
    input  wire apb_req_t          apb_req,        // APB request.
    output apb_rsp_t               apb_rsp,        // APB answer.
    input  wire logic [FREQ_W-1:0] out_freq,       // Output frequency.
    input  wire logic [FREQ_W-1:0] ref_freq,       // Reference frequency.
    input  wire logic [VOLT_W-1:0] bus_voltage,    // DC link bus voltage.
    input  wire logic              dc_braking,     // DC braking active.
    input  wire logic              uv_tripped,     // Undervoltage trip stop.
    input  wire ext_flags_t        ext_flags,      // Flags from the drive.
    input  wire logic              run_request,    // Run command in.
    output logic                   run_enable,     // Run command accepted.
    output logic                   transistor_out_a,
    output logic                   transistor_out_b,
    output logic                   transistor_out_c,
    output logic                   aux_relay_contact,
    output logic                   fault_relay_make_contact,
    output logic                   fault_relay_break_contact,
    output logic                   irq             // Level interrupt.
);

    // The whole state of the block in one record.
    typedef struct packed {
        logic [TERM_N-1:0][CODE_W-1:0] code;         // Select codes.
        logic [FREQ_W-1:0]             detect_level; // Detection level.
        logic [FREQ_W-1:0]             start_freq;   // Running set level.
        logic [FREQ_W-1:0]             stop_freq;    // Running clear level.
        logic [VOLT_W-1:0]             uv_level;     // Undervoltage level.
        logic                          running;
        logic                          reached;
        logic                          threshold;
        logic                          bus_low;
        logic                          run_enable;
        logic [TERM_N-1:0]             term;         // Terminal levels.
        logic [IRQ_W-1:0]              irq_status;   // Sticky events.
        logic [IRQ_W-1:0]              irq_mask;     // Interrupt enables.
        logic [31:0]                   prdata;       // Read data.
        logic                          irq;
    } state_t;

    state_t              cur;        // Registered state.
    state_t              next_state; // Next value of the state.
    flags_t              flags;      // All flags offered to the selectors.
    logic [TERM_N-1:0]   sel_level;  // Selector results before register.
    logic [IRQ_W-1:0]    events;     // Events raised this cycle.
    logic [FREQ_W-1:0]   diff;       // Absolute frequency error.
    logic                setup;      // APB setup phase.
    logic                access;     // APB access phase.
    logic                mapped;     // Address hits a register.
    logic                bad_code;   // Write carries an unusable code.
    logic [2:0]          term_idx;   // Select code register index.

    // Selectors see the registered local flags, so an output lags its
    // flag by one clock; this keeps the comparators off the output path.
    assign flags.running              = cur.running;
    assign flags.speed_reached_flag   = cur.reached;
    assign flags.speed_threshold_flag = cur.threshold;
    assign flags.dc_bus_low_flag      = cur.bus_low;
    assign flags.ext                  = ext_flags;

    // One selector per terminal.
    for (genvar t = 0; t < TERM_N; t++) begin : g_term
        status_select_mux u_sel (
            .code  (cur.code[t]),
            .flags (flags),
            .level (sel_level[t])
        );
    end

    // Bus phase decode and address checks.
    assign setup    = apb_req.psel && !apb_req.penable;
    assign access   = apb_req.psel && apb_req.penable;
    assign term_idx = apb_req.paddr[4:2];

    // Decides whether the address names a register.
    always_comb begin
        mapped = 1'b0;
        if (apb_req.paddr[1:0] == 2'b00) begin
            if (apb_req.paddr <= OFS_IRQ_MASK) begin
                mapped = 1'b1;
            end
        end
    end

    // A write of an unsupported code, or an inverted contactor code, is
    // refused with an error so software learns its setting did not land.
    always_comb begin
        bad_code = 1'b0;
        if (mapped && apb_req.pwrite && apb_req.paddr < OFS_DETECT) begin
            if (apb_req.pwdata[31:CODE_W] != '0) begin
                bad_code = 1'b1;
            end else if (!code_valid(apb_req.pwdata[CODE_W-1:0])) begin
                bad_code = 1'b1;
            end
        end
    end

    // Zero wait states; errors flag unmapped addresses and bad codes.
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = access && (!mapped || bad_code);
    assign apb_rsp.prdata  = cur.prdata;

    // Absolute difference between output and reference frequency.
    always_comb begin
        if (out_freq >= ref_freq) begin
            diff = out_freq - ref_freq;
        end else begin
            diff = ref_freq - out_freq;
        end
    end

    // Next-state logic: flags, terminals, registers and interrupts.
    always_comb begin
        next_state = cur;
        events     = '0;

        // Running flag with start/stop levels; braking forces it off.
        if (dc_braking) begin
            next_state.running = 1'b0;
        end else if (out_freq > cur.start_freq) begin
            next_state.running = 1'b1;
        end else if (out_freq < cur.stop_freq) begin
            next_state.running = 1'b0;
        end

        // Arrival window includes its edge.
        next_state.reached = (diff <= ARRIVAL_TOL);

        // Detect flag; the sum avoids wrapping below a low level.
        if (out_freq > cur.detect_level) begin
            next_state.threshold = 1'b1;
        end else if ({1'b0, out_freq} + {1'b0, DETECT_HYST} <
                     {1'b0, cur.detect_level}) begin
            next_state.threshold = 1'b0;
        end

        // Undervoltage flag; equality holds the previous state.
        if (uv_tripped) begin
            next_state.bus_low = 1'b1;
        end else if (bus_voltage < cur.uv_level) begin
            next_state.bus_low = 1'b1;
        end else if (bus_voltage > cur.uv_level) begin
            next_state.bus_low = 1'b0;
        end

        // Run commands pass only while the bus is healthy.
        next_state.run_enable = run_request && !cur.bus_low;

        // Terminal levels follow the selectors one clock later.
        next_state.term = sel_level;

        // Rising edges of the local flags and refused runs are events.
        events[IRQ_RUNNING] = next_state.running && !cur.running;
        events[IRQ_REACHED] = next_state.reached && !cur.reached;
        events[IRQ_THRESH]  = next_state.threshold && !cur.threshold;
        events[IRQ_BUS_LOW] = next_state.bus_low && !cur.bus_low;
        events[IRQ_REJECT]  = run_request && cur.bus_low;

        // A status read clears only the bits it returned; an event that
        // lands in the setup or access cycle survives for the next read.
        if (access && !apb_req.pwrite && mapped &&
            apb_req.paddr == OFS_IRQ_STATUS) begin
            next_state.irq_status = (cur.irq_status &
                                     ~cur.prdata[IRQ_W-1:0]) | events;
        end else begin
            next_state.irq_status = cur.irq_status | events;
        end

        // Register writes take effect at the end of the access phase.
        if (access && apb_req.pwrite && mapped) begin
            if (apb_req.paddr < OFS_DETECT) begin
                if (!bad_code) begin
                    next_state.code[term_idx] =
                        apb_req.pwdata[CODE_W-1:0];
                end
            end else begin
                case (apb_req.paddr)
                    OFS_DETECT: begin
                        next_state.detect_level = apb_req.pwdata[FREQ_W-1:0];
                    end
                    OFS_START: begin
                        next_state.start_freq = apb_req.pwdata[FREQ_W-1:0];
                    end
                    OFS_STOP: begin
                        next_state.stop_freq = apb_req.pwdata[FREQ_W-1:0];
                    end
                    OFS_UV: begin
                        next_state.uv_level = apb_req.pwdata[VOLT_W-1:0];
                    end
                    OFS_IRQ_MASK: begin
                        next_state.irq_mask = apb_req.pwdata[IRQ_W-1:0];
                    end
                    default: begin
                        // Read-only registers ignore writes.
                        next_state.irq_mask = cur.irq_mask;
                    end
                endcase
            end
        end

        // Read data is captured in the setup cycle and held for access.
        if (setup) begin
            next_state.prdata = '0;
            if (mapped && apb_req.paddr < OFS_DETECT) begin
                next_state.prdata[CODE_W-1:0] = cur.code[term_idx];
            end else if (mapped) begin
                case (apb_req.paddr)
                    OFS_DETECT: begin
                        next_state.prdata[FREQ_W-1:0] = cur.detect_level;
                    end
                    OFS_START: begin
                        next_state.prdata[FREQ_W-1:0] = cur.start_freq;
                    end
                    OFS_STOP: begin
                        next_state.prdata[FREQ_W-1:0] = cur.stop_freq;
                    end
                    OFS_UV: begin
                        next_state.prdata[VOLT_W-1:0] = cur.uv_level;
                    end
                    OFS_FLAGS: begin
                        next_state.prdata[4:0] = {cur.run_enable,
                                                  cur.bus_low,
                                                  cur.threshold,
                                                  cur.reached,
                                                  cur.running};
                    end
                    OFS_IRQ_STATUS: begin
                        next_state.prdata[IRQ_W-1:0] = cur.irq_status;
                    end
                    OFS_IRQ_MASK: begin
                        next_state.prdata[IRQ_W-1:0] = cur.irq_mask;
                    end
                    default: begin
                        next_state.prdata = '0;
                    end
                endcase
            end
        end

        // Interrupt is high while any unmasked status bit is set.
        next_state.irq = |(next_state.irq_status & next_state.irq_mask);
    end

    // State register; reset leaves terminals off and relays released.
    // Codes return to active-on polarity so no terminal starts inverted.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cur              <= '0;
            cur.code         <= RST_CODES;
            cur.detect_level <= RST_DETECT;
            cur.start_freq   <= RST_START;
            cur.stop_freq    <= RST_STOP;
            cur.uv_level     <= RST_UV;
            cur.irq_mask     <= RST_MASK;
        end else begin
            cur <= next_state;
        end
    end

    // Terminal pins. A terminal set to inverted polarity reads active
    // while the drive is unpowered, since an unpowered output is off;
    // the outside must interlock for that and mask the start-up period.
    assign transistor_out_a  = cur.term[TERM_A];
    assign transistor_out_b  = cur.term[TERM_B];
    assign transistor_out_c  = cur.term[TERM_C];
    assign aux_relay_contact = cur.term[TERM_AUX];

    // The fault relay coil drives make closed and break open together.
    assign fault_relay_make_contact  = cur.term[TERM_FAULT];
    assign fault_relay_break_contact = !cur.term[TERM_FAULT];

    // Remaining registered outputs.
    assign run_enable = cur.run_enable;
    assign irq        = cur.irq;

endmodule : status_output_assign_mux

/* File: bench/status_output_assign_mux_checker.sv */
// Port-level assertions for the status output assignment block.
`timescale 1ns/100ps
module status_output_assign_mux_checker
    import drive_output_pkg::*;
(
    input wire logic     clock,
    input wire logic     rstn,
    input wire apb_req_t apb_req,
    input wire apb_rsp_t apb_rsp,
    input wire logic     run_request,
    input wire logic     uv_tripped,
    input wire logic     run_enable,
    input wire logic     fault_relay_make_contact,
    input wire logic     fault_relay_break_contact
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // A completed write of value v to the select code of terminal a.
    sequence s_code_wr(logic [31:0] v);
        apb_req.psel && apb_req.penable && apb_req.pwrite &&
        apb_req.paddr == OFS_CODE0 && apb_req.pwdata == v;
    endsequence
    property p_run_req; run_enable |-> $past(run_request); endproperty
    property p_run_uv; uv_tripped |-> ##2 !run_enable; endproperty
    property p_run_off; !run_request |=> !run_enable; endproperty
    property p_relay;
        fault_relay_break_contact != fault_relay_make_contact;
    endproperty
    property p_ready; apb_rsp.pready; endproperty
    property p_err; apb_rsp.pslverr |-> apb_req.psel && apb_req.penable;
    endproperty
    property p_contact; s_code_wr(32'h000003F3) |-> apb_rsp.pslverr;
    endproperty
    property p_inv; s_code_wr(32'h000003E8) |-> !apb_rsp.pslverr;
    endproperty
    a_run_req: assert property (p_run_req) else $error("run no req");
    a_run_uv: assert property (p_run_uv) else $error("run in trip");
    a_run_off: assert property (p_run_off) else $error("run stuck");
    a_relay: assert property (p_relay) else $error("relay pair");
    a_ready: assert property (p_ready) else $error("not ready");
    a_err: assert property (p_err) else $error("stray error");
    a_contact: assert property (p_contact) else $error("bad code");
    a_inv: assert property (p_inv) else $error("inv refused");
endmodule : status_output_assign_mux_checker
bind status_output_assign_mux status_output_assign_mux_checker chk_inst (.*);

/* File: bench/control_equipment.sv */
// External control equipment that blanks the outputs after power-on.
`timescale 1ns/100ps
module control_equipment #(
    parameter int SETTLE = 16    // Blanking time, shortened from seconds.
) (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic [4:0] terms,   // Terminal levels from the drive.
    output logic [4:0]      seen     // Levels the equipment acts on.
);
    int age;                         // Cycles since power-on.
    // Levels are untrusted while the drive settles after power-on.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            age <= 0;
        else if (age < SETTLE)
            age <= age + 1;
    end
    assign seen = (age < SETTLE) ? 5'h00 : terms;
endmodule : control_equipment

/* File: bench/status_output_assign_mux_tb.sv */
// Self-checking bench for the status output assignment block.
`timescale 1ns/100ps
module status_output_assign_mux_tb
    import drive_output_pkg::*;
;
    logic clock = 0, rstn = 0, dc_braking = 0, uv_tripped = 0, run_request = 0;
    logic [15:0] out_freq = 0, ref_freq = 16'h1770, bus_voltage = 16'h0100;
    apb_req_t    apb_req = '0;
    apb_rsp_t    apb_rsp;
    ext_flags_t  ext_flags = '0;
    logic run_enable, irq, fault_relay_make_contact, fault_relay_break_contact;
    logic transistor_out_a, transistor_out_b, transistor_out_c;
    logic aux_relay_contact, e, inv, f;
    logic [31:0] q, r;
    logic [10:0] c;
    int err_total = 0, num_checks = 0, cyc = 0, seed = 32'hA4C1;
    int pool [18] = '{5, 6, 7, 10, 11, 12, 13, 56, 60, 61, 62, 63, 64, 65,
                      67, 68, 69, 99};
    // Step table: braking or trip, expected levels, frequency or voltage.
    logic [23:0] tab [12] = '{24'h010033, 24'h071771, 24'h07173E,
        24'h031676, 24'h011675, 24'h101675, 24'h000032, 24'h010033,
        24'h0200C7, 24'h0100C9, 24'h1200C9, 24'h0200C8};
    always #20 clock = ~clock;
    status_output_assign_mux status_output_assign_mux_inst (.*);
    control_equipment control_equipment_inst (.clock(clock), .rstn(rstn),
        .terms({transistor_out_c, transistor_out_b, transistor_out_a,
                aux_relay_contact, fault_relay_make_contact}), .seen());
    // Flag expected for a supported select code of an external signal.
    function automatic logic flag_of(logic [10:0] b, ext_flags_t x);
        case (b)
            5: flag_of = x.output_limiting_flag;
            6: flag_of = x.power_loss_restart_flag;
            7: flag_of = x.overload_warning_flag;
            10: flag_of = x.ready;
            11: flag_of = x.line_contactor_drive;
            12: flag_of = x.secondary_contactor_drive;
            13: flag_of = x.primary_contactor_drive;
            56: flag_of = x.motor_overheat_flag;
            67: flag_of = x.motor_stage[6];
            68: flag_of = x.periodic_switch_warning;
            69: flag_of = x.pump_limit_flag;
            99: flag_of = x.any_fault_flag;
            default: flag_of = x.motor_stage[b - 11'h03C];
        endcase
    endfunction : flag_of
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask : chk
    // One APB transfer; holds the request until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        @(posedge clock) apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock) apb_req.penable <= 1'b1;
        do @(posedge clock); while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '0;
    endtask : apb
    task results;
        $display("Checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    // Cuts a hang short well beyond the expected run length.
    always @(posedge clock) if (++cyc == 5000) begin
        err_total++;
        results();
    end
    initial begin
        repeat (8) @(posedge clock);
        chk({transistor_out_a, fault_relay_break_contact}, 32'h1);
        rstn <= 1'b1;
        for (int t = 0; t < 5; t++) begin
            apb(0, 8'(4 * t), 0);
            chk(q, RST_CODES[t]);
        end
        for (int k = 11; k < 14; k++) begin
            apb(1, OFS_CODE0, k + 1000);
            chk(e, 1);
        end
        apb(0, 8'h30, 0);
        chk(e, 1);
        chk(q, 0);
        for (int i = 0; i < 12; i++) begin
            if (i == 8) apb(1, 8'h08, 3);
            {dc_braking, uv_tripped, run_request} <= {i < 8, i > 7, i > 7}
                & {{2{tab[i][20]}}, 1'b1};
            if (i < 8) out_freq <= tab[i][15:0];
            else bus_voltage <= tab[i][15:0];
            repeat (3) @(posedge clock);
            if (i < 8) chk({transistor_out_c, transistor_out_b,
                transistor_out_a}, tab[i][18:16]);
            else chk({transistor_out_c, run_enable},
                tab[i][17:16]);
            if (i == 7) begin
                chk(irq, 0);
                apb(1, OFS_IRQ_MASK, 1);
                @(posedge clock) chk(irq, 1);
                apb(0, OFS_IRQ_STATUS, 0);
                repeat (2) @(posedge clock);
                chk({q[0], irq}, 2);
            end
        end
        for (int n = 0; n < 24; n++) begin
            c = 11'(pool[$unsigned($random(seed)) % 18]);
            inv = $random(seed) & (c < 11 || c > 13);
            r = $random(seed);
            ext_flags <= r[17:0];
            apb(1, OFS_CODE0, c + (inv ? 1000 : 0));
            chk(e, 0);
            apb(1, 8'h10, c + (inv ? 1000 : 0));
            repeat (2) @(posedge clock);
            f = flag_of(c, ext_flags) ^ inv;
            chk(transistor_out_a, f);
            chk(fault_relay_make_contact, f);
        end
        // Running is set here, so its inverted form must read low.
        apb(1, OFS_CODE0, 1000);
        repeat (2) @(posedge clock);
        chk({e, transistor_out_a}, 0);
        results();
    end
endmodule : status_output_assign_mux_tb
